// ### rfsr_pkg.sv
// Shared constants and carrier types of the receive status report block.
`default_nettype none
package rfsr_pkg;
  // Register indices; the byte address of each is four times its index.
  localparam logic [7:0] RFSR_IDX_STATUS = 8'h13;
  localparam logic [7:0] RFSR_IDX_CTRL   = 8'h20;
  localparam logic [7:0] RFSR_IDX_ISTAT  = 8'h21;
  localparam logic [7:0] RFSR_IDX_IMASK  = 8'h22;
  // Status word field positions (least significant bit of each field).
  localparam int RFSR_BYTES_LSB   = 0;
  localparam int RFSR_FRAMES_LSB  = 9;
  localparam int RFSR_LAST_LSB    = 13;
  localparam int RFSR_INTEG_BIT   = 16;
  localparam int RFSR_FRAME_BIT   = 17;
  localparam int RFSR_COLL_BIT    = 18;
  localparam int RFSR_COLLPOS_LSB = 19;
  // Control register field positions.
  localparam int RFSR_C_PAR_EN    = 0;
  localparam int RFSR_C_PAR_ODD   = 1;
  localparam int RFSR_C_CRC_EN    = 2;
  localparam int RFSR_C_OFS_LSB   = 3;
  localparam int RFSR_C_MULTI     = 6;
  localparam int RFSR_C_INV_STOP  = 7;
  localparam int RFSR_C_CPV       = 31;
  // Interrupt status and mask bit positions.
  localparam int RFSR_I_DONE      = 0;
  localparam int RFSR_I_FRAME     = 1;
  localparam int RFSR_I_COLL      = 2;
  localparam int RFSR_IRQ_W       = 3;
  // Reset values.
  localparam logic [7:0]  RFSR_CTRL_RST  = 8'h00;
  localparam logic [2:0]  RFSR_MASK_RST  = 3'h0;
  localparam logic [31:0] RFSR_RDATA_RST = 32'h0000_0000;
  // Receiver sequencing states.
  typedef enum logic [1:0] {
    RFSR_IDLE = 2'b00,
    RFSR_RECV = 2'b01,
    RFSR_HALT = 2'b10
  } rfsr_state_e;
  // Events and levels from the radio decoder, synchronous to pclk.
  typedef struct packed {
    logic rx_enable;   // Receiver armed again; one-cycle pulse.
    logic rx_sof;      // Start of a new reception; one-cycle pulse.
    logic bit_valid;   // One decoded data bit present.
    logic bit_data;    // Value of that data bit.
    logic bit_coll;    // A collision was seen on that data bit.
    logic par_valid;   // One received parity bit present.
    logic par_data;    // Value of that parity bit.
    logic crc_done;    // Received CRC has been compared.
    logic crc_ok;      // Result of that comparison.
    logic stop_err;    // Wrong stop bit.
    logic sof_eof_err; // Missing or wrong type B start or end of frame.
    logic len_err;     // Wrong number of received bytes.
    logic eof;         // Regular end of frame.
    logic mode_106a;   // Passive 106 kbit/s or type A reader mode.
  } rfsr_dec_s;
endpackage : rfsr_pkg
`default_nettype wire

// ### rfsr_sticky.sv
// Sticky flag bank where a hardware set wins over a software clear.
`timescale 1ns/1ps
`default_nettype none
module rfsr_sticky #(
  parameter int W = 3
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output logic      [W-1:0] q
);
  // Next value: keep unless cleared, and any set overrides the clear.
  logic [W-1:0] q_d;
  assign q_d = (q & ~clr) | set;

  // Flags start cleared after reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= q_d;
    end
  end
endmodule : rfsr_sticky
`default_nettype wire

// ### rfsr_parity.sv
// Parity checker for one received byte against its parity bit.
`timescale 1ns/1ps
`default_nettype none
module rfsr_parity #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] data,
  input  wire logic         odd,
  input  wire logic         par_bit,
  output logic              mismatch
);
  // Expected bit makes the total count of ones even, or odd if asked.
  logic expect_bit;
  assign expect_bit = (^data) ^ odd;
  assign mismatch   = expect_bit != par_bit;
endmodule : rfsr_parity
`default_nettype wire

// ### rfsr_top.sv
// Receive frame status report with APB registers and interrupt.
// Summary of operation
// RULE_01: First collision bit position in bits 19-25.
// RULE_02: Collision position includes the first-bit offset.
// RULE_03: Software trusts position only when valid flag set.
// RULE_04: Collision flag bit 18 set on collision.
// RULE_05: Framing fault bit 17 on stop/SOF/EOF/length.
// RULE_06: Framing fault stops reception of the frame.
// RULE_07: Start of reception clears both fault flags.
// RULE_08: Integrity fault bit 16 on parity/CRC error.
// RULE_09: Integrity fault keeps reception running.
// RULE_10: Inverted-parity end criterion sets no integrity fault.
// RULE_11: Valid bits of last byte in 13-15.
// RULE_12: Frame tally 9-12 updated at receive done.
// RULE_13: Byte count 0-8 valid after receive done.
// RULE_14: First bit stored at offset, then following.
// RULE_15: Parity checked per byte when enabled.
// RULE_16: CRC failure feeds integrity fault when enabled.
// RULE_17: New reception clears collision flag and position.
// RULE_18: Status word read-only, upper bits zero.
// RULE_19: Receive done once per frame after update.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rfsr_top #(
  parameter int ADDR_W = 12
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire rfsr_pkg::rfsr_dec_s dec,
  output logic                   rx_halt,
  output logic                   irq
);
  import rfsr_pkg::*;

  // Sequencer state and live frame counters.
  rfsr_state_e state_q, state_d;
  logic [2:0]  bitpos_q, bitpos_d;   // Bit position inside the byte.
  logic [8:0]  bcnt_q, bcnt_d;       // Completed bytes of this frame.
  logic [6:0]  dbits_q, dbits_d;     // Data bit index plus offset.
  logic [7:0]  shreg_q, shreg_d;     // Byte being assembled.
  // Reported status fields.
  logic [6:0]  cpos_q, cpos_d;       // First collision position.
  logic        coll_q, coll_d;       // Collision seen.
  logic        ferr_q, ferr_d;       // Framing fault.
  logic        ierr_q, ierr_d;       // Integrity fault.
  logic [2:0]  last_q, last_d;       // Valid bits of last byte.
  logic [3:0]  frames_q, frames_d;   // Frame tally.
  logic [8:0]  bytes_q, bytes_d;     // Received byte count.
  // Software registers and interrupt state.
  logic [7:0]  ctrl_q;
  logic [2:0]  mask_q;
  logic [2:0]  istat;
  logic        halt_q;
  logic        irq_q;
  logic [31:0] rdata_q;
  logic        slverr_q;
  logic        pready_q;          // Ready, raised for the access cycle.

  // Control fields.
  wire        par_en   = ctrl_q[RFSR_C_PAR_EN];
  wire        par_odd  = ctrl_q[RFSR_C_PAR_ODD];
  wire        crc_en   = ctrl_q[RFSR_C_CRC_EN];
  wire [2:0]  offset   = ctrl_q[RFSR_C_OFS_LSB +: 3];
  wire        multi    = ctrl_q[RFSR_C_MULTI];
  wire        inv_stop = ctrl_q[RFSR_C_INV_STOP];

  // Decoder event qualification; bits only count while receiving.
  wire recv     = state_q == RFSR_RECV;
  wire fault    = dec.stop_err | dec.sof_eof_err | dec.len_err;
  wire frm_hit  = recv & fault;                                  // RULE_05
  wire bit_hit  = recv & dec.bit_valid & ~dec.rx_sof;            // RULE_06
  wire par_mism;
  wire par_chk  = recv & dec.par_valid & par_en & par_mism;      // RULE_15
  wire par_stop = par_chk & inv_stop;                            // RULE_10
  wire par_err  = par_chk & ~inv_stop;                           // RULE_09
  wire crc_err  = recv & dec.crc_done & crc_en & ~dec.crc_ok;    // RULE_16
  wire fin      = ~dec.rx_sof & (frm_hit | (recv & dec.eof) | par_stop);
  wire coll_new = bit_hit & dec.bit_coll & ~coll_q;              // RULE_04
  wire byte_end = bitpos_q == 3'h7;
  wire cpv      = coll_q & dec.mode_106a;                        // RULE_03

  // Parity of the byte assembled before its parity bit arrives.
  rfsr_parity #(
    .W (8)
  ) u_parity (
    .data     (shreg_q),
    .odd      (par_odd),
    .par_bit  (dec.par_data),
    .mismatch (par_mism)
  );

  // Sequencer: a framing fault halts, any end of frame reports.
  always_comb begin
    state_d = state_q;
    case (state_q)
      RFSR_IDLE: begin
        if (dec.rx_sof) state_d = RFSR_RECV;
      end
      RFSR_RECV: begin
        if (dec.rx_sof) state_d = RFSR_RECV;
        else if (frm_hit) state_d = RFSR_HALT;                   // RULE_06
        else if (fin) state_d = RFSR_IDLE;
      end
      RFSR_HALT: begin
        if (dec.rx_sof) state_d = RFSR_RECV;
      end
      default: begin
        state_d = RFSR_IDLE;
      end
    endcase
  end

  // Bit placement and live counters within the frame.
  always_comb begin
    bitpos_d = bitpos_q;
    bcnt_d   = bcnt_q;
    dbits_d  = dbits_q;
    shreg_d  = shreg_q;
    if (dec.rx_sof) begin
      bitpos_d = offset;                                         // RULE_14
      bcnt_d   = 9'h000;
      dbits_d  = {4'h0, offset};                                 // RULE_02
      shreg_d  = 8'h00;
    end else if (bit_hit) begin
      shreg_d[bitpos_q] = dec.bit_data;                          // RULE_14
      bitpos_d = bitpos_q + 3'h1;
      if (byte_end) bcnt_d = bcnt_q + 9'h001;
      if (dbits_q != 7'h7f) dbits_d = dbits_q + 7'h01;
    end
  end

  // Status fields: cleared at start, set during, counts at the end.
  always_comb begin
    cpos_d   = cpos_q;
    coll_d   = coll_q;
    ferr_d   = ferr_q;
    ierr_d   = ierr_q;
    last_d   = last_q;
    frames_d = frames_q;
    bytes_d  = bytes_q;
    if (dec.rx_enable) begin
      frames_d = 4'h0;
      bytes_d  = 9'h000;
    end
    if (dec.rx_sof) begin
      coll_d = 1'b0;                                             // RULE_17
      cpos_d = 7'h00;                                            // RULE_17
      ferr_d = 1'b0;                                             // RULE_07
      ierr_d = 1'b0;                                             // RULE_07
    end else begin
      if (coll_new) begin
        coll_d = 1'b1;                                           // RULE_04
        cpos_d = dbits_q;                                        // RULE_01
      end
      if (frm_hit) ferr_d = 1'b1;                                // RULE_05
      if (par_err | crc_err) ierr_d = 1'b1;                      // RULE_08
      if (fin) begin
        last_d  = bitpos_q;                                      // RULE_11
        bytes_d = bcnt_q + {8'h00, bitpos_q != 3'h0};            // RULE_13
        if (multi) frames_d = frames_q + 4'h1;                   // RULE_12
      end
    end
  end

  // Frame state registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q  <= RFSR_IDLE;
      bitpos_q <= 3'h0;
      bcnt_q   <= 9'h000;
      dbits_q  <= 7'h00;
      shreg_q  <= 8'h00;
      halt_q   <= 1'b0;
    end else begin
      state_q  <= state_d;
      bitpos_q <= bitpos_d;
      bcnt_q   <= bcnt_d;
      dbits_q  <= dbits_d;
      shreg_q  <= shreg_d;
      halt_q   <= state_d == RFSR_HALT;                          // RULE_06
    end
  end

  // Reported status registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpos_q   <= 7'h00;
      coll_q   <= 1'b0;
      ferr_q   <= 1'b0;
      ierr_q   <= 1'b0;
      last_q   <= 3'h0;
      frames_q <= 4'h0;
      bytes_q  <= 9'h000;
    end else begin
      cpos_q   <= cpos_d;
      coll_q   <= coll_d;
      ferr_q   <= ferr_d;
      ierr_q   <= ierr_d;
      last_q   <= last_d;
      frames_q <= frames_d;
      bytes_q  <= bytes_d;
    end
  end

  // Status word image; unused upper bits stay zero.
  logic [31:0] status_w;
  always_comb begin
    status_w = 32'h0000_0000;                                    // RULE_18
    status_w[RFSR_BYTES_LSB +: 9]   = bytes_q;
    status_w[RFSR_FRAMES_LSB +: 4]  = frames_q;
    status_w[RFSR_LAST_LSB +: 3]    = last_q;
    status_w[RFSR_INTEG_BIT]        = ierr_q;
    status_w[RFSR_FRAME_BIT]        = ferr_q;
    status_w[RFSR_COLL_BIT]         = coll_q;
    status_w[RFSR_COLLPOS_LSB +: 7] = cpos_q;
  end

  // APB address decode; only aligned word accesses hit a register.
  wire [7:0] widx    = paddr[9:2];
  wire       aligned = (paddr[1:0] == 2'b00) && (paddr >> 10) == '0;
  wire       h_stat  = aligned && widx == RFSR_IDX_STATUS;
  wire       h_ctrl  = aligned && widx == RFSR_IDX_CTRL;
  wire       h_istat = aligned && widx == RFSR_IDX_ISTAT;
  wire       h_imask = aligned && widx == RFSR_IDX_IMASK;
  wire       mapped  = h_stat | h_ctrl | h_istat | h_imask;
  wire       setup   = psel & ~penable;
  wire       access  = psel & penable;
  wire       wr_acc  = access & pwrite;
  wire       rd_istat = access & ~pwrite & h_istat;

  // Read data selection; prepared in setup, shown during access.
  logic [31:0] rsel;
  always_comb begin
    rsel = 32'h0000_0000;
    if (h_stat) rsel = status_w;
    else if (h_ctrl) rsel = {cpv, 23'h000000, ctrl_q};
    else if (h_istat) rsel = {29'h0000_0000, istat};
    else if (h_imask) rsel = {29'h0000_0000, mask_q};
  end

  // Bus slave registers; writes land at the access edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q  <= RFSR_RDATA_RST;
      slverr_q <= 1'b0;
      pready_q <= 1'b0;
      ctrl_q   <= RFSR_CTRL_RST;
      mask_q   <= RFSR_MASK_RST;
    end else begin
      if (setup) rdata_q <= pwrite ? RFSR_RDATA_RST : rsel;
      // Error and ready come from flops and stand in the access cycle.
      slverr_q <= setup & ~mapped;
      pready_q <= setup;
      if (wr_acc && h_ctrl) ctrl_q <= pwdata[7:0];
      if (wr_acc && h_imask) mask_q <= pwdata[2:0];
    end
  end

  // Event flags: set by the frame, cleared by reading them.
  wire [2:0] iset = {coll_new, frm_hit & ~dec.rx_sof, fin};      // RULE_19
  rfsr_sticky #(
    .W (RFSR_IRQ_W)
  ) u_istat (
    .pclk    (pclk),
    .presetn (presetn),
    .set     (iset),
    .clr     ({RFSR_IRQ_W{rd_istat}}),
    .q       (istat)
  );

  // Interrupt level from any unmasked flag.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(istat & mask_q);
    end
  end

  assign prdata  = rdata_q;
  assign pready  = pready_q;
  assign pslverr = slverr_q;
  assign rx_halt = halt_q;
  assign irq     = irq_q;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_FRAME_SET: // RULE_05
    assert property (recv && fault && !dec.rx_sof |=> ferr_q)
    else $error("Framing fault not flagged.");
  AST_FRAME_HALT: // RULE_06
    assert property (frm_hit && !dec.rx_sof |=> rx_halt && !recv
      ##1 ($past(dec.rx_sof) || bcnt_q == $past(bcnt_q)))
    else $error("Reception not stopped on framing fault.");
  AST_SOF_CLEARS: // RULE_07
    assert property (dec.rx_sof |=> !ferr_q && !ierr_q && !coll_q)
    else $error("Flags not cleared at start of reception.");
  AST_INTEG_RUNS: // RULE_09
    assert property (par_err && !fault && !dec.eof && !dec.rx_sof
      |=> recv && ierr_q)
    else $error("Integrity fault aborted or not flagged.");
  AST_INV_PAR: // RULE_10
    assert property (par_stop && !ierr_q && !crc_err && !dec.rx_sof
      |=> !ierr_q && !recv)
    else $error("Inverted parity stop flagged an integrity fault.");
  AST_COLL_POS: // RULE_02
    assert property (coll_new && !dec.rx_sof
      |=> coll_q && cpos_q == $past(dbits_q))
    else $error("Collision position wrong.");
  AST_FRAMES: // RULE_12
    assert property (fin && multi && !dec.rx_enable
      |=> frames_q == $past(frames_q) + 4'h1)
    else $error("Frame tally not advanced at receive done.");
  AST_DONE_IRQ: // RULE_19
    assert property (fin && mask_q[RFSR_I_DONE] && !wr_acc
      |=> istat[RFSR_I_DONE] ##1 irq)
    else $error("Receive done interrupt missing.");
  AST_RO_STATUS: // RULE_18
    assert property (wr_acc && h_stat && !recv && !dec.rx_sof
      && !dec.rx_enable |=> $stable(status_w) && status_w[31:26] == 6'h00)
    else $error("Status word changed by a write.");
endmodule : rfsr_top
`default_nettype wire

// ### rfsr_dec_model.sv
// Behavioural radio decoder model that feeds events to the status block.
`timescale 1ns/1ps
`default_nettype none
module rfsr_dec_model (
  input  wire logic                pclk,
  output var  rfsr_pkg::rfsr_dec_s dec
);
  import rfsr_pkg::*;
  logic mode_lvl; // Passive 106 kbit/s or type A level, set by the bench.

  // Nothing is reported until the bench starts a reception.
  initial begin
    mode_lvl = 1'b0;
    dec = '0;
  end

  // Present one event for a cycle, then rest for gap idle cycles.
  // A gap of zero leaves the event up so the next one follows at once.
  task automatic send(input rfsr_dec_s v, input int gap);
    rfsr_dec_s idle;
    idle = '0;
    idle.mode_106a = mode_lvl;
    v.mode_106a = mode_lvl;
    @(posedge pclk);
    dec <= v;
    repeat (gap) begin
      @(posedge pclk);
      dec <= idle;
    end
  endtask : send

  // Data bits go out least significant first; bit ci carries a collision.
  task automatic bits(input logic [15:0] d, input int n, input int ci,
                      input int gap);
    rfsr_dec_s v;
    for (int i = 0; i < n; i++) begin
      v = '0;
      v.bit_valid = 1'b1;
      v.bit_data = d[i];
      v.bit_coll = (i == ci);
      send(v, gap);
    end
  endtask : bits
endmodule : rfsr_dec_model
`default_nettype wire

// ### tb_top.sv
// Self-checking testbench of the receive status report block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rfsr_pkg::*;
  // Single decoder events, one bit set each.
  localparam rfsr_dec_s E_EN = 14'h2000, E_SOF = 14'h1000, E_PV = 14'h0100,
    E_CD = 14'h0040, E_CO = 14'h0020, E_STOP = 14'h0010,
    E_SOFE = 14'h0008, E_LEN = 14'h0004, E_EOF = 14'h0002;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, rx_halt, irq, er;
  rfsr_dec_s   dec;
  int          n_fail, checks;

  rfsr_top rfsr_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .dec(dec),
    .rx_halt(rx_halt), .irq(irq));
  rfsr_dec_model rfsr_dec_model_i (.pclk(pclk), .dec(dec));

  // Free-running 250 MHz clock.
  always #2 pclk = ~pclk;

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  // Compares one value and counts the result.
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  // One APB transfer; read data lands in rd and the error flag in er.
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [31:0] wd);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k == 50) begin
      n_fail++;
      summarize();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Waits a bounded time for the interrupt line.
  task automatic wait_irq;
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 40) begin
      @(posedge pclk);
      k++;
    end
    if (k == 40) begin
      n_fail++;
      summarize();
    end
  endtask : wait_irq

  // Short names for the decoder model's tasks.
  task automatic sd(input rfsr_dec_s v, input int g);
    rfsr_dec_model_i.send(v, g);
  endtask : sd

  task automatic bt(input logic [15:0] d, input int n, input int c,
                    input int g);
    rfsr_dec_model_i.bits(d, n, c, g);
  endtask : bt

  // A byte, an event, optionally more bits and the event again, then end.
  task automatic run(input logic [7:0] d, input rfsr_dec_s t, input int m);
    sd(E_EN, 0);
    sd(E_SOF, 0);
    bt({8'h00, d}, 8, -1, 0);
    sd(t, 0);
    if (m > 0) begin
      bt({8'h00, d}, m, -1, 0);
      sd(t, 0);
    end
    sd(E_EOF, 1);
  endtask : run

  // Expected status word from its fields; fl holds bits 18 down to 16.
  function automatic logic [31:0] st(input int b, input int f, input int l,
                                     input int fl, input int p);
    st = 32'(b) | (32'(f) << RFSR_FRAMES_LSB) | (32'(l) << RFSR_LAST_LSB)
       | (32'(fl) << RFSR_INTEG_BIT) | (32'(p) << RFSR_COLLPOS_LSB);
  endfunction : st

  // Reset values, a write to the read-only word and an unmapped read.
  task automatic t_regs;
    apb(1'b1, RFSR_IDX_STATUS, 32'hffff_ffff);
    chk("status write err", 32'h0, {31'h0, er});
    apb(1'b0, RFSR_IDX_STATUS, 32'h0);
    chk("status", 32'h0, rd);
    apb(1'b0, 8'hff, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    apb(1'b0, RFSR_IDX_IMASK, 32'h0);
    chk("mask reset", 32'h0, rd);
    apb(1'b1, RFSR_IDX_IMASK, 32'h7);
    $display("end t_regs");
  endtask : t_regs

  // Collision with a first-bit offset of 2, then a clean slow frame.
  task automatic t_coll;
    apb(1'b1, RFSR_IDX_CTRL, 32'h10);
    rfsr_dec_model_i.mode_lvl = 1'b1;
    sd(E_EN, 0);
    sd(E_SOF, 0);
    bt(16'h02a5, 10, 3, 0);
    sd(E_EOF, 1);
    wait_irq();
    apb(1'b0, RFSR_IDX_STATUS, 32'h0);
    chk("status", st(2, 0, 4, 4, 5), rd);
    apb(1'b0, RFSR_IDX_CTRL, 32'h0);
    chk("pos valid", 32'h1, {31'h0, rd[31]});
    apb(1'b0, RFSR_IDX_ISTAT, 32'h0);
    chk("istat", 32'h5, rd);
    apb(1'b0, RFSR_IDX_ISTAT, 32'h0);
    chk("istat cleared", 32'h0, rd);
    chk("irq cleared", 32'h0, {31'h0, irq});
    sd(E_EN, 0);
    sd(E_SOF, 0);
    bt(16'h00ff, 8, -1, 2);
    sd(E_EOF, 1);
    wait_irq();
    apb(1'b0, RFSR_IDX_STATUS, 32'h0);
    chk("status", st(2, 0, 2, 0, 0), rd);
    apb(1'b0, RFSR_IDX_ISTAT, 32'h0);
    $display("end t_coll");
  endtask : t_coll

  // Parity and CRC faults, and the inverted parity end criterion.
  task automatic t_integ;
    rfsr_dec_model_i.mode_lvl = 1'b0;
    apb(1'b1, RFSR_IDX_CTRL, 32'h1);
    run(8'h01, E_PV, 8);
    wait_irq();
    apb(1'b0, RFSR_IDX_STATUS, 32'h0);
    chk("status", st(2, 0, 0, 1, 0), rd);
    chk("halt", 32'h0, {31'h0, rx_halt});
    apb(1'b0, RFSR_IDX_ISTAT, 32'h0);
    apb(1'b1, RFSR_IDX_CTRL, 32'h4);
    run(8'hff, E_CD, 0);
    wait_irq();
    apb(1'b0, RFSR_IDX_STATUS, 32'h0);
    chk("status", st(1, 0, 0, 1, 0), rd);
    apb(1'b0, RFSR_IDX_ISTAT, 32'h0);
    run(8'hff, E_CD | E_CO, 0);
    wait_irq();
    apb(1'b0, RFSR_IDX_STATUS, 32'h0);
    chk("status", st(1, 0, 0, 0, 0), rd);
    apb(1'b0, RFSR_IDX_ISTAT, 32'h0);
    // Odd parity: a byte of one set bit with a clear parity bit is good.
    apb(1'b1, RFSR_IDX_CTRL, 32'h3);
    run(8'h01, E_PV, 0);
    wait_irq();
    apb(1'b0, RFSR_IDX_STATUS, 32'h0);
    chk("status odd", st(1, 0, 0, 0, 0), rd);
    apb(1'b0, RFSR_IDX_ISTAT, 32'h0);
    apb(1'b1, RFSR_IDX_CTRL, 32'h81);
    run(8'h01, E_PV, 0);
    wait_irq();
    apb(1'b0, RFSR_IDX_STATUS, 32'h0);
    chk("status", st(1, 0, 0, 0, 0), rd);
    apb(1'b0, RFSR_IDX_ISTAT, 32'h0);
    $display("end t_integ");
  endtask : t_integ

  // Each framing fault halts the frame; the next start clears it.
  task automatic t_fault;
    rfsr_dec_s fl [3];
    fl = '{E_STOP, E_SOFE, E_LEN};
    apb(1'b1, RFSR_IDX_CTRL, 32'h0);
    for (int i = 0; i < 3; i++) begin
      run(8'h5a, fl[i], 8);
      wait_irq();
      chk("halt", 32'h1, {31'h0, rx_halt});
      apb(1'b0, RFSR_IDX_STATUS, 32'h0);
      chk("status", st(1, 0, 0, 2, 0), rd);
      apb(1'b0, RFSR_IDX_ISTAT, 32'h0);
      chk("istat", 32'h3, rd);
      // One more edge so the halt flag launched by the start has settled.
      sd(E_SOF, 2);
      chk("halt", 32'h0, {31'h0, rx_halt});
      apb(1'b0, RFSR_IDX_STATUS, 32'h0);
      chk("framing", 32'h0, {31'h0, rd[RFSR_FRAME_BIT]});
    end
    $display("end t_fault");
  endtask : t_fault

  // Three frames in multi-frame mode with the interrupt masked.
  task automatic t_multi;
    apb(1'b1, RFSR_IDX_IMASK, 32'h0);
    apb(1'b1, RFSR_IDX_CTRL, 32'h40);
    sd(E_EN, 0);
    repeat (3) begin
      sd(E_SOF, 0);
      bt(16'h00c3, 8, -1, 0);
      sd(E_EOF, 1);
    end
    repeat (4) @(posedge pclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b0, RFSR_IDX_STATUS, 32'h0);
    chk("frames", 32'h3, {28'h0, rd[12:9]});
    apb(1'b1, RFSR_IDX_IMASK, 32'h7);
    wait_irq();
    apb(1'b0, RFSR_IDX_ISTAT, 32'h0);
    chk("istat", 32'h1, rd);
    apb(1'b1, RFSR_IDX_CTRL, 32'h0);
    run(8'h3c, E_EOF, 0);
    wait_irq();
    apb(1'b0, RFSR_IDX_STATUS, 32'h0);
    chk("frames", 32'h0, {28'h0, rd[12:9]});
    $display("end t_multi");
  endtask : t_multi

  // Main sequence: reset for two cycles, then every scenario.
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    n_fail = 0;
    checks = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_coll();
    t_integ();
    t_fault();
    t_multi();
    summarize();
  end

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    summarize();
  end
endmodule : tb_top
`default_nettype wire
